// File: src/dscp_port.sv
// Serial control port: mode selection, 3-wire and 2-wire receivers, chaining.
`timescale 1ns/1ps
`default_nettype none
module dscp_port
    import dscp_pkg::*;
#(
    parameter int unsigned REG_COUNT = 9,
    parameter int unsigned HW_PINS   = 8
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        control_mode_select_pin,
    output logic                             mode_probe_pull_up,
    input  wire logic                        diff_mono_force_pin,
    input  wire logic                        control_serial_clock,
    input  wire logic                        control_data_in,
    output logic                             control_data_out,
    output logic                             control_data_oe,
    input  wire logic                        control_latch,
    input  wire logic                        bus_address_select,
    output logic                             chain_data_out,
    output logic                             chain_data_oe,
    input  wire logic                        device_ready,
    input  wire logic [HW_PINS-1:0]          hw_config_pins,
    output logic [HW_PINS-1:0]               hw_config_applied,
    output dscp_mode_t                       control_mode,
    output logic                             diff_mono_active,
    output logic [REG_COUNT*DATA_W-1:0]      regs_flat
);

    localparam int unsigned SYNC_W = 7 + HW_PINS;
    localparam int unsigned PCNT_W = $clog2(PROBE_CYCLES + 1);

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    logic [SYNC_W-1:0]  sync_v;
    logic               mode_s;
    logic               diff_s;
    logic               scl_s;
    logic               sda_s;
    logic               latch_s;
    logic               addr_sel_s;
    logic               ready_s;
    logic [HW_PINS-1:0] hw_s;

    dscp_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({hw_config_pins, device_ready, bus_address_select, control_latch,
                    control_data_in, control_serial_clock, diff_mono_force_pin,
                    control_mode_select_pin}),
        .sync_out (sync_v)
    );

    assign {hw_s, ready_s, addr_sel_s, latch_s, sda_s, scl_s, diff_s, mode_s} = sync_v;

    // Edge detection works on synchronised levels only.
    logic scl_d_r;
    logic sda_d_r;
    logic latch_d_r;
    logic scl_rise;
    logic scl_fall;
    logic latch_rise;
    logic tw_start;
    logic tw_stop;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r   <= 1'b0;
            sda_d_r   <= 1'b1;
            latch_d_r <= 1'b1;
        end else begin
            scl_d_r   <= scl_s;
            sda_d_r   <= sda_s;
            latch_d_r <= latch_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_d_r;
    assign scl_fall   = ~scl_s & scl_d_r;
    assign latch_rise = latch_s & ~latch_d_r;
    // A data change while the clock stays high marks start or stop.
    assign tw_start   = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign tw_stop    = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ****************************************************************
    // Mode selection
    // ****************************************************************
    // The mode pin is probed with alternating weak pulls: a pin that
    // follows the pull is floating. Sampling waits a full phase so the
    // pad and the synchroniser have settled.
    logic [PCNT_W-1:0] probe_cnt_r;
    logic [PCNT_W-1:0] probe_cnt_nxt;
    logic              probe_up_r;
    logic              probe_up_nxt;
    logic              seen_up_r;
    logic              seen_up_nxt;
    dscp_mode_t        pin_mode_r;
    dscp_mode_t        pin_mode_nxt;

    always_comb begin
        probe_cnt_nxt = probe_cnt_r + PCNT_W'(1);
        probe_up_nxt  = probe_up_r;
        seen_up_nxt   = seen_up_r;
        pin_mode_nxt  = pin_mode_r;
        if (probe_cnt_r == PCNT_W'(PROBE_CYCLES - 1)) begin
            probe_cnt_nxt = '0;
            probe_up_nxt  = ~probe_up_r;
            if (probe_up_r) begin
                seen_up_nxt = mode_s;
            end else if (seen_up_r && !mode_s) begin
                pin_mode_nxt = DSCP_MODE_WIRE2;
            end else if (mode_s) begin
                pin_mode_nxt = DSCP_MODE_WIRE3;
            end else begin
                pin_mode_nxt = DSCP_MODE_HW;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            probe_cnt_r <= '0;
            probe_up_r  <= 1'b1;
            seen_up_r   <= 1'b0;
            pin_mode_r  <= DSCP_MODE_HW;
        end else begin
            probe_cnt_r <= probe_cnt_nxt;
            probe_up_r  <= probe_up_nxt;
            seen_up_r   <= seen_up_nxt;
            pin_mode_r  <= pin_mode_nxt;
        end
    end

    assign mode_probe_pull_up = probe_up_r;

    assign control_mode     = diff_s ? DSCP_MODE_HW : pin_mode_r;
    assign diff_mono_active = diff_s;

    assign hw_config_applied = (control_mode == DSCP_MODE_HW) ? hw_s : '0;

    // ****************************************************************
    // Three-wire receiver and chain output
    // ****************************************************************
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;
    logic              chain_q_r;
    logic              chain_q_nxt;
    dscp_write_t       w3_wr;
    logic              wire3;
    logic              chain_en;

    assign wire3 = (control_mode == DSCP_MODE_WIRE3);

    always_comb begin
        shift_nxt   = shift_r;
        chain_q_nxt = chain_q_r;
        if (wire3 && scl_rise) begin
            chain_q_nxt = shift_r[WORD_W-1];
            shift_nxt   = {shift_r[WORD_W-2:0], sda_s};
        end
    end

    // Reset to ones so a chained neighbour sees the null register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r   <= SHIFT_RESET;
            chain_q_r <= 1'b1;
        end else begin
            shift_r   <= shift_nxt;
            chain_q_r <= chain_q_nxt;
        end
    end

    assign w3_wr.valid     = wire3 & latch_rise;
    assign w3_wr.word.addr = shift_r[WORD_W-1 -: ADDR_W];
    assign w3_wr.word.data = shift_r[DATA_W-1:0];

    assign chain_data_oe  = wire3 & chain_en;
    assign chain_data_out = chain_q_r;

    // ****************************************************************
    // Two-wire receiver
    // ****************************************************************
    dscp_tw_state_t     tw_state_r;
    dscp_tw_state_t     tw_state_nxt;
    logic [2:0]         bit_cnt_r;
    logic [2:0]         bit_cnt_nxt;
    logic [1:0]         byte_idx_r;
    logic [1:0]         byte_idx_nxt;
    logic               byte_done_r;
    logic               byte_done_nxt;
    logic [BYTE_W-1:0]  rx_byte_r;
    logic [BYTE_W-1:0]  rx_byte_nxt;
    logic [BYTE_W-1:0]  hi_byte_r;
    logic [BYTE_W-1:0]  hi_byte_nxt;
    logic               ack_r;
    logic               ack_nxt;
    dscp_write_t        w2_wr;
    logic               wire2;
    logic [6:0]         own_addr;

    assign wire2 = (control_mode == DSCP_MODE_WIRE2);

    assign own_addr = addr_sel_s ? DEV_ADDR_HIGH : DEV_ADDR_LOW;

    always_comb begin
        tw_state_nxt  = tw_state_r;
        bit_cnt_nxt   = bit_cnt_r;
        byte_idx_nxt  = byte_idx_r;
        byte_done_nxt = byte_done_r;
        rx_byte_nxt   = rx_byte_r;
        hi_byte_nxt   = hi_byte_r;
        ack_nxt       = ack_r;
        w2_wr         = '0;
        if (!wire2 || tw_stop) begin
            tw_state_nxt = DSCP_TW_IDLE;
            ack_nxt      = 1'b0;
        end else if (tw_start) begin
            ack_nxt = 1'b0;
            if (tw_state_r == DSCP_TW_IDLE || tw_state_r == DSCP_TW_WAIT_STOP) begin
                tw_state_nxt  = DSCP_TW_SHIFT;
                bit_cnt_nxt   = '0;
                byte_idx_nxt  = BYTE_DEV;
                byte_done_nxt = 1'b0;
            end else begin
                tw_state_nxt = DSCP_TW_IDLE;
            end
        end else begin
            case (tw_state_r)
                DSCP_TW_SHIFT: begin
                    if (scl_rise && !byte_done_r) begin
                        rx_byte_nxt   = {rx_byte_r[BYTE_W-2:0], sda_s};
                        bit_cnt_nxt   = bit_cnt_r + 3'h1;
                        byte_done_nxt = (bit_cnt_r == BIT_LAST);
                    end else if (scl_fall && byte_done_r) begin
                        byte_done_nxt = 1'b0;
                        if (byte_idx_r != BYTE_DEV
                            || (rx_byte_r[BYTE_W-1:1] == own_addr && !rx_byte_r[0])) begin
                            tw_state_nxt = DSCP_TW_ACK;
                            ack_nxt      = 1'b1;
                        end else begin
                            tw_state_nxt = DSCP_TW_IDLE;
                        end
                    end
                end
                DSCP_TW_ACK: begin
                    // Release the line after the acknowledge clock pulse.
                    if (scl_fall) begin
                        ack_nxt = 1'b0;
                        if (byte_idx_r == BYTE_LO) begin
                            w2_wr.valid     = 1'b1;
                            w2_wr.word      = {hi_byte_r, rx_byte_r};
                            tw_state_nxt    = DSCP_TW_WAIT_STOP;
                        end else begin
                            if (byte_idx_r == BYTE_HI) begin
                                hi_byte_nxt = rx_byte_r;
                            end
                            byte_idx_nxt = byte_idx_r + 2'h1;
                            tw_state_nxt = DSCP_TW_SHIFT;
                        end
                    end
                end
                DSCP_TW_WAIT_STOP: begin
                    tw_state_nxt = DSCP_TW_WAIT_STOP;
                end
                default: begin
                    tw_state_nxt = DSCP_TW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tw_state_r  <= DSCP_TW_IDLE;
            bit_cnt_r   <= '0;
            byte_idx_r  <= BYTE_DEV;
            byte_done_r <= 1'b0;
            rx_byte_r   <= '0;
            hi_byte_r   <= '0;
            ack_r       <= 1'b0;
        end else begin
            tw_state_r  <= tw_state_nxt;
            bit_cnt_r   <= bit_cnt_nxt;
            byte_idx_r  <= byte_idx_nxt;
            byte_done_r <= byte_done_nxt;
            rx_byte_r   <= rx_byte_nxt;
            hi_byte_r   <= hi_byte_nxt;
            ack_r       <= ack_nxt;
        end
    end

    // Open drain: only ever pulls the data line low.
    assign control_data_out = 1'b0;
    assign control_data_oe  = ack_r;

    // ****************************************************************
    // Commit into the register bank
    // ****************************************************************
    dscp_write_t commit;

    always_comb begin
        commit       = w3_wr.valid ? w3_wr : w2_wr;
        commit.valid = commit.valid & ready_s & (commit.word.addr != NULL_REG);
    end

    dscp_reg_bank #(
        .REG_COUNT (REG_COUNT)
    ) u_bank (
        .clk       (clk),
        .rst_n     (rst_n),
        .wr        (commit),
        .regs_flat (regs_flat)
    );

    assign chain_en = regs_flat[int'(CHAIN_REG) * DATA_W + CHAIN_BIT];

endmodule : dscp_port
`default_nettype wire

// File: src/dscp_pkg.sv
// Shared constants, types and encodings of the serial control port.
package dscp_pkg;

    // ****************************************************************
    // Word layout and register map
    // ****************************************************************
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned ADDR_W      = 7;
    localparam int unsigned DATA_W      = 9;
    localparam int unsigned BYTE_W      = 8;
    localparam logic [6:0]  CHAIN_REG   = 7'h08;  // Register holding chain enable.
    localparam int unsigned CHAIN_BIT   = 5;
    localparam logic [8:0]  REG_RESET   = 9'h000;
    localparam logic [6:0]  NULL_REG    = 7'h7f;  // Writes here change nothing.
    localparam logic [15:0] SHIFT_RESET = 16'hffff;

    // ****************************************************************
    // Two-wire bus addresses and byte positions
    // ****************************************************************
    localparam logic [6:0]  DEV_ADDR_LOW  = 7'h1a;  // 0011010
    localparam logic [6:0]  DEV_ADDR_HIGH = 7'h1b;  // 0011011
    localparam logic [1:0]  BYTE_DEV      = 2'h0;
    localparam logic [1:0]  BYTE_HI       = 2'h1;
    localparam logic [1:0]  BYTE_LO       = 2'h2;
    localparam logic [2:0]  BIT_LAST      = 3'h7;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned PROBE_TIME_NS = 1000;  // Each pull phase of the mode probe.
    localparam int unsigned PROBE_CYCLES  =
        (PROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES   = 2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        DSCP_MODE_HW,
        DSCP_MODE_WIRE3,
        DSCP_MODE_WIRE2
    } dscp_mode_t;

    typedef enum logic [1:0] {
        DSCP_TW_IDLE,
        DSCP_TW_SHIFT,
        DSCP_TW_ACK,
        DSCP_TW_WAIT_STOP
    } dscp_tw_state_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [8:0] data;
    } dscp_word_t;

    typedef struct packed {
        logic       valid;
        dscp_word_t word;
    } dscp_write_t;

endpackage : dscp_pkg

// File: src/dscp_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module dscp_sync
    import dscp_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // Both stages reset low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule : dscp_sync
`default_nettype wire

// File: src/dscp_reg_bank.sv
// Register bank written by committed control words.
`timescale 1ns/1ps
`default_nettype none
module dscp_reg_bank
    import dscp_pkg::*;
#(
    parameter int unsigned REG_COUNT = 9
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire dscp_write_t                 wr,
    output logic [REG_COUNT*DATA_W-1:0]      regs_flat
);

    logic [DATA_W-1:0] regs_r   [REG_COUNT];
    logic [DATA_W-1:0] regs_nxt [REG_COUNT];

    // Addresses past the bank, including the null register, are dropped.
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            regs_nxt[i] = regs_r[i];
            if (wr.valid && (wr.word.addr == ADDR_W'(i))) begin
                regs_nxt[i] = wr.word.data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_r[i] <= REG_RESET;
            end
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // Flatten the bank for the downstream audio logic.
    genvar g;
    generate
        for (g = 0; g < REG_COUNT; g++) begin : g_flat
            assign regs_flat[g*DATA_W +: DATA_W] = regs_r[g];
        end
    endgenerate

endmodule : dscp_reg_bank
`default_nettype wire

// File: tb/dscp_port_asserts.sv
// Concurrent checks on the pins of the serial control port.
`timescale 1ns/1ps
`default_nettype none
module dscp_port_asserts
    import dscp_pkg::*;
#(
    parameter int unsigned REG_COUNT = 9,
    parameter int unsigned HW_PINS   = 8
) (
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire logic                        diff_mono_force_pin,
    input wire logic                        control_serial_clock,
    input wire logic                        control_data_out,
    input wire logic                        control_data_oe,
    input wire logic                        chain_data_out,
    input wire logic                        chain_data_oe,
    input wire logic [HW_PINS-1:0]          hw_config_applied,
    input wire dscp_mode_t                  control_mode,
    input wire logic                        diff_mono_active,
    input wire logic [REG_COUNT*DATA_W-1:0] regs_flat
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic       sclk_r;
    logic [3:0] since_r;
    // Age of the last control clock rise; saturates so idle time never wraps.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_r  <= 1'b0;
            since_r <= 4'hf;
        end else begin
            sclk_r  <= control_serial_clock;
            since_r <= (control_serial_clock && !sclk_r) ? 4'h0
                     : (since_r == 4'hf) ? 4'hf : since_r + 4'h1;
        end
    end
    a_chain_needs_wire3: assert property (chain_data_oe |-> control_mode == DSCP_MODE_WIRE3)
        else $error("chain output enabled outside three-wire mode");
    a_chain_needs_bit: assert property (chain_data_oe |-> regs_flat[8*DATA_W+CHAIN_BIT])
        else $error("chain output enabled while its register bit is clear");
    a_diff_forces_hw: assert property (diff_mono_force_pin [*4] |-> control_mode == DSCP_MODE_HW)
        else $error("mono pin did not force hardware mode");
    a_mono_flag_set: assert property (diff_mono_force_pin [*4] |-> diff_mono_active)
        else $error("mono pin did not raise the mono flag");
    a_hw_pins_ignored: assert property (control_mode != DSCP_MODE_HW |-> hw_config_applied == '0)
        else $error("hardware pins applied in a serial mode");
    a_ack_only_wire2: assert property (control_data_oe |-> control_mode == DSCP_MODE_WIRE2)
        else $error("data line pulled outside two-wire mode");
    a_ack_pulls_low: assert property (control_data_oe |-> !control_data_out)
        else $error("acknowledge drives the line high");
    a_ack_ends_soon: assert property ($rose(control_data_oe) |-> ##[1:40] !control_data_oe)
        else $error("acknowledge held too long");
    a_chain_on_clock: assert property ($changed(chain_data_out) |-> since_r < 4'ha)
        else $error("chain output moved without a control clock rise");
    a_regs_reset_zero: assert property ($rose(rst_n) |-> regs_flat == '0)
        else $error("registers not cleared by reset");
endmodule : dscp_port_asserts
bind dscp_port dscp_port_asserts #(.REG_COUNT(REG_COUNT), .HW_PINS(HW_PINS)) dscp_port_asserts_i (
    .clk(clk), .rst_n(rst_n), .diff_mono_force_pin(diff_mono_force_pin),
    .control_serial_clock(control_serial_clock), .control_data_out(control_data_out),
    .control_data_oe(control_data_oe), .chain_data_out(chain_data_out),
    .chain_data_oe(chain_data_oe), .hw_config_applied(hw_config_applied),
    .control_mode(control_mode), .diff_mono_active(diff_mono_active), .regs_flat(regs_flat));
`default_nettype wire

// File: tb/dscp_host_model.sv
// Host controller model driving the control clock, data and latch pins.
`timescale 1ns/1ps
`default_nettype none
module dscp_host_model #(
    parameter int unsigned HP = 4
) (
    input  wire logic clk,
    input  wire logic line,
    output logic      scl,
    output logic      dat,
    output logic      latch
);
    // Idle: clock still, line released, latch high.
    initial begin
        scl   = 1'b0;
        dat   = 1'b1;
        latch = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w
    task automatic bit3(input logic b);
        dat = b;
        w(HP);
        scl = 1'b1;
        w(HP);
        scl = 1'b0;
    endtask : bit3
    task automatic word3(input logic [15:0] x);
        for (int i = 15; i >= 0; i--) bit3(x[i]);
    endtask : word3
    // latch framing; data inverts once the frame is over, never holding a stale bit.
    task automatic lat(input logic v);
        latch = v;
        if (v) dat = ~dat;
        w(HP);
    endtask : lat
    task automatic start();
        dat = 1'b1;
        scl = 1'b1;
        w(12);
        dat = 1'b0;
        w(12);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        dat = 1'b0;
        w(HP);
        scl = 1'b1;
        w(12);
        dat = 1'b1;
        w(12);
    endtask : stop
    task automatic byte2(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            w(HP);
            dat = (i == 0) ? 1'b1 : b[i-1];
            w(HP);
            scl = 1'b1;
            w(HP);
            ack = !line;
            scl = 1'b0;
        end
    endtask : byte2
endmodule : dscp_host_model
`default_nettype wire

// File: tb/dscp_port_tb.sv
// Self-checking testbench of the serial control port.
`timescale 1ns/1ps
`default_nettype none
module dscp_port_tb;
    import dscp_pkg::*;
    logic        clk, rst_n, diff, ready, asel;
    logic [1:0]  sel;
    logic [7:0]  hw, hw_app;
    logic        pull_up, doe, dout, cdo, coe, dma, scl, hdat, lat, k;
    logic [80:0] regs, exp = '0;
    logic [6:0]  dev, a;
    logic [8:0]  d;
    logic [15:0] x;
    dscp_mode_t  mode;
    int          bad_count = 0, checks = 0, cyc = 0;
    always #25 clk = ~clk;
    // The mode pin floats to whichever pull the probe applies; open drain ANDs the data line.
    wire mpin = (sel == 2'h2) ? pull_up : sel[0];
    wire din  = hdat & ~(doe & (sel == 2'h2));
    dscp_host_model host_i (.clk(clk), .line(din), .scl(scl), .dat(hdat), .latch(lat));
    dscp_port dscp_port_i (.clk(clk), .rst_n(rst_n), .control_mode_select_pin(mpin),
        .mode_probe_pull_up(pull_up), .diff_mono_force_pin(diff),
        .control_serial_clock(scl), .control_data_in(din), .control_data_out(dout),
        .control_data_oe(doe), .control_latch(lat), .bus_address_select(asel),
        .chain_data_out(cdo), .chain_data_oe(coe), .device_ready(ready),
        .hw_config_pins(hw), .hw_config_applied(hw_app), .control_mode(mode),
        .diff_mono_active(dma), .regs_flat(regs));
    task automatic chk(input logic [80:0] seen, input logic [80:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // Writes that are refused leave the expected image untouched.
    task automatic wr3(input logic [6:0] ra, input logic [8:0] rd);
        host_i.lat(1'b0);
        host_i.word3({ra, rd});
        host_i.lat(1'b1);
        host_i.w(8);
        if (ra < 7'h09 && ready) exp[ra*9 +: 9] = rd;
        chk(regs, exp);
    endtask : wr3
    // A hang counts as a mismatch; the ceiling is well above the expected run.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clk   = 1'b0;
        rst_n = 1'b0;
        diff  = 1'b0;
        ready = 1'b1;
        asel  = 1'b0;
        sel   = 2'h1;
        hw    = 8'h00;
        void'($urandom(32'hc694));
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        hw = 8'($urandom);
        host_i.w(60);
        chk(mode, DSCP_MODE_WIRE3);
        chk(hw_app, 8'h00);
        for (int i = 0; i < 9; i++) wr3(7'(i), {1'b0, 8'($urandom)});
        wr3(7'h7f, 9'h1ff);
        $display("three-wire writes done");
        wr3(7'h08, 9'h020);
        chk(coe, 1'b1);
        // Old word is pushed out by an all-ones word, sixteen clocks later.
        x = 16'($urandom);
        host_i.lat(1'b0);
        host_i.word3(x);
        for (int i = 15; i >= 0; i--) begin
            host_i.bit3(1'b1);
            host_i.w(2);
            chk(cdo, x[i]);
        end
        host_i.lat(1'b1);
        host_i.w(8);
        chk(regs, exp);
        ready = 1'b0;
        host_i.w(6);
        // Inverted data, so a write that slips through always shows.
        wr3(7'h01, {1'b0, ~exp[16:9]});
        ready = 1'b1;
        diff = 1'b1;
        host_i.w(8);
        chk({mode, dma, coe, hw_app}, {DSCP_MODE_HW, 2'b10, hw});
        diff = 1'b0;
        $display("chain and override done");
        sel = 2'h2;
        // A change late in a probe phase can need one more full probe round.
        host_i.w(100);
        chk({mode, coe}, {DSCP_MODE_WIRE2, 1'b0});
        // Good write, other address, read bit, stray stop after the second byte.
        for (int c = 0; c < 4; c++) begin
            asel = 1'($urandom);
            host_i.w(6);
            dev = asel ? DEV_ADDR_HIGH : DEV_ADDR_LOW;
            a = 7'($urandom % 9);
            d = {1'b0, 8'($urandom)};
            host_i.start();
            host_i.byte2({dev ^ {6'h00, c == 1}, c == 2}, k);
            chk(k, c != 1 && c != 2);
            if (k) begin
                host_i.byte2({a, d[8]}, k);
                chk(k, 1'b1);
            end
            if (k && c == 0) begin
                host_i.byte2(d[7:0], k);
                chk(k, 1'b1);
                exp[a*9 +: 9] = d;
            end
            host_i.stop();
            host_i.w(8);
            chk(regs, exp);
        end
        $display("two-wire writes done");
        sel = 2'h0;
        hw = 8'($urandom);
        host_i.w(100);
        chk({mode, hw_app}, {DSCP_MODE_HW, hw});
        $display("hardware mode done");
        tally_and_finish();
    end
endmodule : dscp_port_tb
`default_nettype wire
